// >>> rtl/puv_pkg.sv
// Package with command codes, field layouts, reset values and timing constants
package puv_pkg;

	// Command codes of the three protection commands
	localparam logic [7:0] CMD_UV_LIMIT    = 8'h44;
	localparam logic [7:0] CMD_UV_RESPONSE = 8'h45;
	localparam logic [7:0] CMD_OC_LIMIT    = 8'h46;
	localparam logic [7:0] PHASE_ALL       = 8'hFF;

	// Response byte field positions
	localparam int ACT_HI   = 7;
	localparam int ACT_LO   = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DLY_HI   = 2;
	localparam int DLY_LO   = 0;

	// Linear format field positions
	localparam int EXP_HI = 15;
	localparam int EXP_LO = 11;
	localparam int MAN_HI = 10;

	// Undervoltage action and retry codes
	localparam logic [1:0] ACT_IGNORE  = 2'h0;
	localparam logic [1:0] ACT_DELAYED = 2'h1;
	localparam logic [1:0] ACT_NOW     = 2'h2;
	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_EVER  = 3'h7;

	// Threshold steps in fortieths of the target: 60 % to 95 % by 2.5 %
	localparam int           UV_STEP_DEN  = 40;
	localparam int           UV_STEP_BASE = 24;
	localparam int           UV_STEPS     = 15;
	localparam logic [3:0]   UV_STEP_MAX  = 4'hE;

	// Overcurrent limits in quarter amperes
	localparam int             OC_EXP_QUARTER = 2;
	localparam logic [15:0]    OC_MIN_Q       = 16'h0020;
	localparam logic [15:0]    OC_MAX_Q       = 16'h00F8;
	localparam int             OC_STEP_SHIFT  = 3;

	// Values after reset
	localparam logic [15:0] UV_LIMIT_RST    = 16'h0000;
	localparam logic [3:0]  UV_STEP_RST     = 4'h0;
	localparam logic [7:0]  UV_RESPONSE_RST = 8'h80;
	localparam logic [15:0] OC_LIMIT_RST    = 16'hF0F8;

	// Status bit positions
	localparam int SB_NOTA     = 0;
	localparam int SB_CML      = 1;
	localparam int SB_IOUT_OC  = 4;
	localparam int SW_IOUT     = 14;
	localparam int SW_VOUT     = 15;
	localparam int SV_UV_FAULT = 4;
	localparam int SC_BAD_CMD  = 7;
	localparam int SC_BAD_DATA = 6;

	// Timing
	localparam int CLK_FREQ_HZ    = 25_000_000;
	localparam int PWM_CLK_HZ     = 500_000;
	localparam int PWM_DIV        = CLK_FREQ_HZ / PWM_CLK_HZ;
	localparam int RISE_TIME_US   = 3000;
	localparam int RISE_CYCLES    = RISE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int DLY_SHORT      = 1;
	localparam int DLY_MID        = 3;
	localparam int DLY_LONG       = 7;

	// Shutdown sequencer states, Gray coded along the fault path
	typedef enum logic [1:0] {
		SEQ_RUN     = 2'b00,
		SEQ_DELAY   = 2'b01,
		SEQ_HICCUP  = 2'b11,
		SEQ_LATCHED = 2'b10
	} puv_state_type;

endpackage

// >>> rtl/puv_seq_if.sv
// Interface between the command block and the undervoltage sequencer
`timescale 1ns/1ps
interface puv_seq_if;
	logic       uvTrip;
	logic [1:0] uvActionSelect;
	logic [2:0] uvRestartCount;
	logic [2:0] uvDelaySelect;
	logic       pwmTick;
	logic       outputOn;
	logic       latchedOff;

	modport ctrl (output uvTrip, uvActionSelect, uvRestartCount,
		uvDelaySelect, pwmTick, input outputOn, latchedOff);
	modport seq (input uvTrip, uvActionSelect, uvRestartCount,
		uvDelaySelect, pwmTick, output outputOn, latchedOff);
endinterface

// >>> rtl/puv_uv_sequencer.sv
// Undervoltage shutdown, hiccup and restart sequencer
`timescale 1ns/1ps
module puv_uv_sequencer
	import puv_pkg::*;
#(
	parameter int RISE_CYC = RISE_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic opOn,
	input  wire logic startupDone,
	puv_seq_if.seq    sq
);
	puv_state_type stateQ, stateD;
	logic [2:0]  pwmCntQ, pwmCntD;
	logic [31:0] riseCntQ, riseCntD;
	logic [2:0]  unitsQ, unitsD;
	logic [2:0]  triesQ, triesD;
	logic [2:0]  dlyLen;
	logic [2:0]  hicUnits;

	// Delay and hiccup length from the delay field
	always_comb begin
		if (sq.uvDelaySelect <= 3'h1) begin
			dlyLen   = 3'(DLY_SHORT);
			hicUnits = 3'h1;
		end else if (sq.uvDelaySelect <= 3'h4) begin
			dlyLen   = 3'(DLY_MID);
			hicUnits = sq.uvDelaySelect;
		end else begin
			dlyLen   = 3'(DLY_LONG);
			hicUnits = sq.uvDelaySelect;
		end
	end

	// Next state of the sequencer
	always_comb begin
		stateD   = stateQ;
		pwmCntD  = pwmCntQ;
		riseCntD = riseCntQ;
		unitsD   = unitsQ;
		triesD   = triesQ;
		case (stateQ)
			SEQ_RUN: begin
				if (startupDone)
					triesD = 3'h0;
				if (sq.uvTrip && opOn) begin
					pwmCntD  = 3'h0;
					riseCntD = '0;
					unitsD   = 3'h0;
					if (sq.uvActionSelect == ACT_DELAYED)
						stateD = SEQ_DELAY;
					else if (sq.uvActionSelect == ACT_NOW)
						stateD = (sq.uvRestartCount == RETRY_LATCH) ?
							SEQ_LATCHED : SEQ_HICCUP;
				end
			end
			SEQ_DELAY: begin
				if (!sq.uvTrip)
					stateD = SEQ_RUN;
				else if (sq.pwmTick) begin
					pwmCntD = pwmCntQ + 3'h1;
					if (pwmCntQ + 3'h1 >= dlyLen)
						stateD = (sq.uvRestartCount == RETRY_LATCH) ?
							SEQ_LATCHED : SEQ_HICCUP;
				end
			end
			SEQ_HICCUP: begin
				if (riseCntQ >= 32'(RISE_CYC - 1)) begin
					riseCntD = '0;
					unitsD   = unitsQ + 3'h1;
					if (unitsQ + 3'h1 >= hicUnits) begin
						stateD = SEQ_RUN;
						if (sq.uvRestartCount != RETRY_EVER)
							triesD = triesQ + 3'h1;
					end
				end else
					riseCntD = riseCntQ + 32'h1;
				if (sq.uvRestartCount != RETRY_EVER &&
					triesQ >= sq.uvRestartCount)
					stateD = SEQ_LATCHED;
			end
			SEQ_LATCHED: begin
				stateD = SEQ_LATCHED;
			end
			default: stateD = SEQ_RUN;
		endcase
		// Commanded off clears any fault sequence
		if (!opOn) begin
			stateD = SEQ_RUN;
			triesD = 3'h0;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stateQ   <= SEQ_RUN;
			pwmCntQ  <= 3'h0;
			riseCntQ <= '0;
			unitsQ   <= 3'h0;
			triesQ   <= 3'h0;
		end else begin
			stateQ   <= stateD;
			pwmCntQ  <= pwmCntD;
			riseCntQ <= riseCntD;
			unitsQ   <= unitsD;
			triesQ   <= triesD;
		end
	end

	assign sq.outputOn   = opOn && (stateQ == SEQ_RUN ||
		stateQ == SEQ_DELAY);
	assign sq.latchedOff = (stateQ == SEQ_LATCHED);
endmodule

// >>> rtl/puv_fault_config.sv
// Undervoltage and overcurrent fault configuration and response block
//
// Operation
// - Hold the 16-bit undervoltage fault limit, read/write, as threshold.
// - Map a written limit to a percentage of target, rounding down.
// - Supported thresholds are 60 % to 95 % of target by 2.5 %.
// - An out-of-range undervoltage limit write flags invalid data and alerts.
// - Undervoltage fault sets byte, word and vout status bits, then alerts.
// - Action field: 0 ignore, 1 delayed off, 2 immediate off, else invalid.
// - Retry field 0 latches off; 1 to 6 retries that often then latches.
// - Retry field 7 retries forever until commanded off.
// - Delay codes 0-1 one PWM clock, 2-4 three, 5-7 seven.
// - Hiccup period is rise time times a factor growing with the code.
// - Unsupported response byte writes are rejected, flagged and alerted.
// - Overcurrent fault when measured current reaches the hardware limit.
// - Each device keeps its own limit; stack limit is least times phases.
// - Current limit is linear: 5-bit exponent resets to -2, 11-bit mantissa.
// - Per phase up to 62 A; all-phases selector up to 62 A times phases.
// - An out-of-range current limit write flags invalid data and alerts.
// - Hardware limit 8 A to 62 A by 2 A, rounding up, clamping below.
// - All-phases write divides by phase count; read multiplies by it.
`timescale 1ns/1ps
module puv_fault_config
	import puv_pkg::*;
#(
	parameter int PHASES   = 2,
	parameter int RISE_CYC = RISE_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        cmdValid,
	input  wire logic        cmdWrite,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [15:0] cmdWrData,
	input  wire logic [7:0]  phaseSelect,
	input  wire logic        clearFaults,
	input  wire logic [15:0] voutTarget,
	input  wire logic [15:0] voutSense,
	input  wire logic [15:0] ioutQuarterAmps,
	input  wire logic        opOn,
	input  wire logic        startupDone,
	output logic      [15:0] rdData,
	output logic             rdValid,
	output logic      [7:0]  statusByte,
	output logic      [15:0] statusWord,
	output logic      [7:0]  statusVout,
	output logic      [7:0]  statusCml,
	output logic             uvFaultFlag,
	output logic             ocFaultFlag,
	output logic             ocFaultEvent,
	output logic      [15:0] perPhaseCurrentLimit,
	output logic             outputEnable,
	output logic             smbAlertOut,
	output logic             smbAlertOeN
);
	puv_seq_if sq ();

	logic [15:0] uvLimitQ, uvLimitD;
	logic [3:0]  uvStepQ, uvStepD;
	logic [7:0]  uvRespQ, uvRespD;
	logic [15:0] ocLimitQ, ocLimitD;
	logic [15:0] ocHwQ, ocHwD;
	logic [15:0] rdDataQ, rdDataD;
	logic        rdValidQ, rdValidD;
	logic [7:0]  sByteQ, sByteD;
	logic [15:0] sWordQ, sWordD;
	logic [7:0]  sVoutQ, sVoutD;
	logic [7:0]  sCmlQ, sCmlD;
	logic        ocTripQ, ocTripD;
	logic [6:0]  pwmDivQ, pwmDivD;

	// Combinational helpers of the command path
	logic [23:0] limTimes40;
	logic [23:0] senseTimes40;
	logic [3:0]  stepFound;
	logic        stepValid;
	logic [23:0] uvThresh;
	logic        uvTrip;
	logic        wrUvLim, wrUvResp, wrOcLim, badCmd;
	logic        uvRespBad;
	logic        ocBad;
	logic signed [31:0] ocQuarter;
	logic signed [31:0] ocPerPhase;
	logic signed [31:0] ocRounded;
	logic signed [10:0] manWr;
	logic signed [10:0] manRd;
	logic signed [31:0] manRdWide;
	logic [15:0] ocStoreWord;

	// Convert a linear word to signed quarter amperes
	function automatic logic signed [31:0] linToQuarter(
		input logic [15:0] w);
		logic signed [4:0]  e;
		logic signed [31:0] m;
		logic signed [31:0] sh;
		e  = w[EXP_HI:EXP_LO];
		m  = 32'(signed'(w[MAN_HI:0]));
		sh = 32'(e) + 32'(OC_EXP_QUARTER);
		if (sh >= 0)
			linToQuarter = (sh > 16) ? 32'sh7FFF_FFFF : (m <<< sh);
		else
			linToQuarter = m >>> (-sh);
	endfunction

	// Threshold step search: largest step not above the written limit
	always_comb begin
		// Scaled by forty so that 2.5 % steps stay whole numbers
		limTimes40 = 24'(cmdWrData) * 24'(UV_STEP_DEN);
		stepFound  = 4'h0;
		stepValid  = 1'b0;
		for (int k = 0; k < UV_STEPS; k++) begin
			if (24'(voutTarget) * 24'(UV_STEP_BASE + k) <= limTimes40) begin
				stepFound = 4'(k);
				stepValid = 1'b1;
			end
		end
		// Above the top step is out of range as well
		if (limTimes40 > 24'(voutTarget) * 24'(UV_STEP_BASE + UV_STEPS - 1))
			stepValid = 1'b0;
	end

	// Undervoltage comparator against the selected share of target
	always_comb begin
		uvThresh     = 24'(voutTarget) * 24'(UV_STEP_BASE + 32'(uvStepQ));
		senseTimes40 = 24'(voutSense) * 24'(UV_STEP_DEN);
		uvTrip       = senseTimes40 < uvThresh;
	end

	// Overcurrent limit conversion, range check and hardware step
	always_comb begin
		ocQuarter  = linToQuarter(cmdWrData);
		ocPerPhase = (phaseSelect == PHASE_ALL) ?
			ocQuarter / PHASES : ocQuarter;
		ocBad = (ocPerPhase < 0) ||
			(ocPerPhase > 32'(OC_MAX_Q));
		if (ocPerPhase < 32'(OC_MIN_Q))
			ocRounded = 32'(OC_MIN_Q);
		else
			ocRounded = ((ocPerPhase + 7) >>> OC_STEP_SHIFT) <<<
				OC_STEP_SHIFT;
		// Stored share truncates the same way as the range check
		manWr = signed'(cmdWrData[MAN_HI:0]);
		ocStoreWord = (phaseSelect == PHASE_ALL) ?
			{cmdWrData[EXP_HI:EXP_LO], 11'(manWr / 11'(PHASES))} :
			cmdWrData;
		manRd     = signed'(ocLimitQ[MAN_HI:0]);
		manRdWide = 32'(manRd) * PHASES;
	end

	// Command decode
	always_comb begin
		wrUvLim   = cmdValid && cmdWrite && cmdCode == CMD_UV_LIMIT;
		wrUvResp  = cmdValid && cmdWrite && cmdCode == CMD_UV_RESPONSE;
		wrOcLim   = cmdValid && cmdWrite && cmdCode == CMD_OC_LIMIT;
		badCmd    = cmdValid && cmdCode != CMD_UV_LIMIT &&
			cmdCode != CMD_UV_RESPONSE && cmdCode != CMD_OC_LIMIT;
		uvRespBad = cmdWrData[ACT_HI:ACT_LO] == 2'h3;
	end

	// Next values of the configuration registers
	always_comb begin
		uvLimitD = uvLimitQ;
		uvStepD  = uvStepQ;
		uvRespD  = uvRespQ;
		ocLimitD = ocLimitQ;
		ocHwD    = ocHwQ;
		if (wrUvLim && stepValid) begin
			uvLimitD = cmdWrData;
			uvStepD  = stepFound;
		end
		if (wrUvResp && !uvRespBad)
			uvRespD = cmdWrData[7:0];
		if (wrOcLim && !ocBad) begin
			ocLimitD = ocStoreWord;
			ocHwD    = ocRounded[15:0];
		end
	end

	// Read path, answered one cycle after the request
	always_comb begin
		rdValidD = cmdValid && !cmdWrite && !badCmd;
		rdDataD  = rdDataQ;
		if (cmdValid && !cmdWrite) begin
			case (cmdCode)
				CMD_UV_LIMIT:    rdDataD = uvLimitQ;
				CMD_UV_RESPONSE: rdDataD = {8'h00, uvRespQ};
				CMD_OC_LIMIT: begin
					if (phaseSelect == PHASE_ALL)
						rdDataD = {ocLimitQ[EXP_HI:EXP_LO],
							manRdWide[MAN_HI:0]};
					else
						rdDataD = ocLimitQ;
				end
				default: rdDataD = 16'h0000;
			endcase
		end
	end

	// Status flags: a new event wins over a clear in the same cycle
	always_comb begin
		ocTripD = ioutQuarterAmps >= ocHwQ;
		sByteD  = clearFaults ? 8'h00 : sByteQ;
		sWordD  = clearFaults ? 16'h0000 : sWordQ;
		sVoutD  = clearFaults ? 8'h00 : sVoutQ;
		sCmlD   = clearFaults ? 8'h00 : sCmlQ;
		if ((wrUvLim && !stepValid) || (wrUvResp && uvRespBad) ||
			(wrOcLim && ocBad)) begin
			sCmlD[SC_BAD_DATA] = 1'b1;
			sByteD[SB_CML]     = 1'b1;
		end
		if (badCmd) begin
			sCmlD[SC_BAD_CMD] = 1'b1;
			sByteD[SB_CML]    = 1'b1;
		end
		if (uvTrip && opOn && uvRespQ[ACT_HI:ACT_LO] != 2'h3) begin
			sByteD[SB_NOTA]     = 1'b1;
			sWordD[SW_VOUT]     = 1'b1;
			sVoutD[SV_UV_FAULT] = 1'b1;
		end
		if (ocTripD) begin
			sByteD[SB_IOUT_OC] = 1'b1;
			sWordD[SW_IOUT]    = 1'b1;
		end
		sWordD[7:0] = sByteD;
	end

	// PWM clock enable divider
	always_comb begin
		pwmDivD = (pwmDivQ == 7'(PWM_DIV - 1)) ? 7'h00 : pwmDivQ + 7'h01;
	end

	// Register stage for configuration, status and read data
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			uvLimitQ <= UV_LIMIT_RST;
			uvStepQ  <= UV_STEP_RST;
			uvRespQ  <= UV_RESPONSE_RST;
			ocLimitQ <= OC_LIMIT_RST;
			ocHwQ    <= OC_MAX_Q;
			rdDataQ  <= 16'h0000;
			rdValidQ <= 1'b0;
			sByteQ   <= 8'h00;
			sWordQ   <= 16'h0000;
			sVoutQ   <= 8'h00;
			sCmlQ    <= 8'h00;
			ocTripQ  <= 1'b0;
			pwmDivQ  <= 7'h00;
		end else begin
			uvLimitQ <= uvLimitD;
			uvStepQ  <= uvStepD;
			uvRespQ  <= uvRespD;
			ocLimitQ <= ocLimitD;
			ocHwQ    <= ocHwD;
			rdDataQ  <= rdDataD;
			rdValidQ <= rdValidD;
			sByteQ   <= sByteD;
			sWordQ   <= sWordD;
			sVoutQ   <= sVoutD;
			sCmlQ    <= sCmlD;
			ocTripQ  <= ocTripD;
			pwmDivQ  <= pwmDivD;
		end
	end

	// Hand-over to the shutdown sequencer
	assign sq.uvTrip         = uvTrip;
	assign sq.uvActionSelect = uvRespQ[ACT_HI:ACT_LO];
	assign sq.uvRestartCount = uvRespQ[RETRY_HI:RETRY_LO];
	assign sq.uvDelaySelect  = uvRespQ[DLY_HI:DLY_LO];
	assign sq.pwmTick        = (pwmDivQ == 7'(PWM_DIV - 1));

	puv_uv_sequencer #(
		.RISE_CYC (RISE_CYC)
	) uSeq (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.opOn        (opOn),
		.startupDone (startupDone),
		.sq          (sq.seq)
	);

	// Read answer
	assign rdData               = rdDataQ;
	assign rdValid              = rdValidQ;

	// Status registers
	assign statusByte           = sByteQ;
	assign statusWord           = sWordQ;
	assign statusVout           = sVoutQ;
	assign statusCml            = sCmlQ;

	// Fault flags and hardware limit
	assign uvFaultFlag          = sVoutQ[SV_UV_FAULT];
	assign ocFaultFlag          = sByteQ[SB_IOUT_OC];
	assign ocFaultEvent         = ocTripQ;  // To the overcurrent response
	assign perPhaseCurrentLimit = ocHwQ;

	// Converter enable and alert pin
	assign outputEnable         = sq.outputOn;
	assign smbAlertOut          = 1'b0;     // Open drain, only pulls low
	assign smbAlertOeN          = ~(|sByteQ);
endmodule

// >>> testbench/puv_fault_checker.sv
// Checker of command port and fault status relations
`timescale 1ns/1ps
module puv_fault_checker
	import puv_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        cmdValid,
	input wire logic        cmdWrite,
	input wire logic [7:0]  cmdCode,
	input wire logic [15:0] cmdWrData,
	input wire logic [7:0]  phaseSelect,
	input wire logic        rdValid,
	input wire logic [7:0]  statusByte,
	input wire logic [15:0] statusWord,
	input wire logic [7:0]  statusCml,
	input wire logic        uvFaultFlag,
	input wire logic        ocFaultFlag,
	input wire logic        ocFaultEvent,
	input wire logic [15:0] perPhaseCurrentLimit,
	input wire logic        smbAlertOeN
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Command port answers and refusals
	a_read_answer: assert property (cmdValid && !cmdWrite &&
		cmdCode == CMD_UV_LIMIT |=> rdValid)
		else $error("read of limit gave no answer");
	a_answer_cause: assert property (rdValid |->
		$past(cmdValid && !cmdWrite)) else $error("answer without read");
	a_bad_response: assert property (cmdValid && cmdWrite &&
		cmdCode == CMD_UV_RESPONSE && cmdWrData[7:6] == 2'h3 |=>
		statusCml[SC_BAD_DATA] && statusByte[SB_CML])
		else $error("bad response byte accepted");
	a_bad_current: assert property (cmdValid && cmdWrite &&
		cmdCode == CMD_OC_LIMIT && phaseSelect != PHASE_ALL &&
		cmdWrData[15:11] == 5'h1E && cmdWrData[10:0] > 11'h0F8 |=>
		statusCml[SC_BAD_DATA]) else $error("bad current limit accepted");
	a_alert_low: assert property ($rose(statusByte[SB_CML]) |->
		##[0:1] !smbAlertOeN) else $error("alert not pulled low");

	// Fault flags and hardware limit range
	a_uv_status: assert property (uvFaultFlag |->
		statusByte[SB_NOTA] && statusWord[SW_VOUT])
		else $error("undervoltage status incomplete");
	a_oc_flag: assert property (ocFaultEvent |=>
		ocFaultFlag && statusWord[SW_IOUT])
		else $error("overcurrent not flagged");
	a_hw_step: assert property (perPhaseCurrentLimit >= OC_MIN_Q &&
		perPhaseCurrentLimit <= OC_MAX_Q &&
		perPhaseCurrentLimit[2:0] == 3'h0)
		else $error("hardware current limit off step");
endmodule

bind puv_fault_config puv_fault_checker chk (.clk_sys, .rst, .cmdValid,
	.cmdWrite, .cmdCode, .cmdWrData, .phaseSelect, .rdValid, .statusByte,
	.statusWord, .statusCml, .uvFaultFlag, .ocFaultFlag, .ocFaultEvent,
	.perPhaseCurrentLimit, .smbAlertOeN);

// >>> testbench/puv_host_model.sv
// Host model that issues commands on the command port
`timescale 1ns/1ps
module puv_host_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] rdData,
	input  wire logic        rdValid,
	output logic             cmdValid,
	output logic             cmdWrite,
	output logic      [7:0]  cmdCode,
	output logic      [15:0] cmdWrData,
	output logic      [7:0]  phaseSelect
);
	// Quiet bus at time zero
	initial begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'h00;
		cmdWrData = 16'h0000;
		phaseSelect = 8'h00;
	end

	// One command, held over the taking edge; idle code and data lines then invert
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic [7:0] ph,
		output logic [15:0] q, output logic v);
		@(negedge clk_sys);
		cmdValid = 1'b1;
		cmdWrite = w;
		cmdCode = c;
		cmdWrData = d;
		phaseSelect = ph;
		@(posedge clk_sys);
		@(negedge clk_sys);
		q = rdData;
		v = rdValid;
		cmdValid = 1'b0;
		cmdCode = ~c;
		cmdWrData = ~d;
	endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the fault configuration block
`timescale 1ns/1ps
module testbench;
	import puv_pkg::*;
	logic        clk_sys, rst, clearFaults, opOn, startupDone;
	logic [15:0] voutTarget, voutSense, ioutQuarterAmps, rdData;
	logic [15:0] cmdWrData, perPhaseCurrentLimit, statusWord, rdQ;
	logic [7:0]  cmdCode, phaseSelect, statusByte, statusVout, statusCml;
	logic        cmdValid, cmdWrite, rdValid, uvFaultFlag, ocFaultFlag;
	logic        ocFaultEvent, outputEnable, smbAlertOut, smbAlertOeN, rdV;
	int          err_count, n_compared, cycles, uvLim, ocPer, lim, n, hw;
	int          mTab[5] = '{100, 20, 249, 248, 500};

	puv_fault_config #(.PHASES(2), .RISE_CYC(20)) dut (.clk_sys, .rst,
		.cmdValid, .cmdWrite, .cmdCode, .cmdWrData, .phaseSelect,
		.clearFaults, .voutTarget, .voutSense, .ioutQuarterAmps, .opOn,
		.startupDone, .rdData, .rdValid, .statusByte, .statusWord,
		.statusVout, .statusCml, .uvFaultFlag, .ocFaultFlag, .ocFaultEvent,
		.perPhaseCurrentLimit, .outputEnable, .smbAlertOut, .smbAlertOeN);
	puv_host_model host (.clk_sys, .rdData, .rdValid, .cmdValid, .cmdWrite,
		.cmdCode, .cmdWrData, .phaseSelect);

	// Clock at 25 MHz
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("compared %0d, mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask

	task automatic cmd(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic [7:0] ph);
		host.xfer(w, c, d, ph, rdQ, rdV);
	endtask

	task automatic clr;
		@(negedge clk_sys);
		clearFaults = 1'b1;
		@(negedge clk_sys);
		clearFaults = 1'b0;
	endtask

	// Write, check refusal flag, clear, read back with the given selector
	task automatic wr_rd(input logic [7:0] c, input logic [15:0] d,
		input logic [7:0] ph, input logic ok, input logic [15:0] e);
		cmd(1'b1, c, d, ph);
		chk("bad data flag", !ok, statusCml[SC_BAD_DATA]);
		chk("comm flag", !ok, statusByte[SB_CML]);
		clr();
		cmd(1'b0, c, 16'h0000, ph);
		chk("read answer", 1'b1, rdV);
		chk("read back", e, rdQ);
	endtask

	task automatic wait_oe(input logic v, input int lim);
		n = 0;
		while (outputEnable !== v && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
	endtask

	initial begin
		rst = 1'b1;
		clearFaults = 1'b0;
		opOn = 1'b0;
		startupDone = 1'b0;
		voutTarget = 16'h03E8;
		voutSense = 16'h03E8;
		ioutQuarterAmps = 16'h0000;
		uvLim = 0;
		ocPer = 248;
		void'($urandom(32'h703B9A73));
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;

		// Values after reset and an unknown command
		cmd(1'b0, CMD_UV_LIMIT, 16'h0000, 8'h00);
		chk("uv limit", UV_LIMIT_RST, rdQ);
		cmd(1'b0, CMD_OC_LIMIT, 16'h0000, 8'h00);
		chk("oc limit", 16'hF0F8, rdQ);
		chk("hw limit", 16'h00F8, perPhaseCurrentLimit);
		cmd(1'b0, 8'h47, 16'h0000, 8'h00);
		chk("unknown answered", 1'b0, rdV);
		chk("bad command", 1'b1, statusCml[SC_BAD_CMD]);
		chk("alert", 1'b0, smbAlertOeN);
		chk("alert out", 1'b0, smbAlertOut);
		clr();
		$display("test reset done");

		// Random undervoltage limits against a target of 1000
		for (int i = 0; i < 8; i++) begin
			lim = 500 + $urandom_range(499, 0);
			if (lim * 40 >= 24000 && lim * 40 <= 38000)
				uvLim = lim;
			wr_rd(CMD_UV_LIMIT, lim[15:0], 8'h00, uvLim == lim,
				uvLim[15:0]);
		end
		$display("test uv limit done");

		// Every action code, the last one refused
		for (int a = 0; a < 4; a++)
			wr_rd(CMD_UV_RESPONSE, {8'h00, a[1:0], 6'h00}, 8'h00, a != 3,
				a == 3 ? 16'h0080 : 16'(a * 64));
		$display("test response done");

		// Current limits per phase, rounding, clamping, refusals
		for (int i = 0; i < 5; i++) begin
			if (mTab[i] <= 248)
				ocPer = mTab[i];
			hw = ocPer < 32 ? 32 : (ocPer + 7) / 8 * 8;
			wr_rd(CMD_OC_LIMIT, 16'hF000 | 16'(mTab[i]), i == 4 ? PHASE_ALL
				: 8'h00, mTab[i] <= 248,
				16'hF000 | 16'(i == 4 ? ocPer * 2 : ocPer));
			chk("hw limit", 16'(hw), perPhaseCurrentLimit);
		end
		wr_rd(CMD_OC_LIMIT, 16'hF0C8, PHASE_ALL, 1'b1, 16'hF0C8);
		cmd(1'b0, CMD_OC_LIMIT, 16'h0000, 8'h00);
		chk("phase share", 16'hF064, rdQ);
		chk("hw limit", 16'h0068, perPhaseCurrentLimit);
		ioutQuarterAmps = 16'h0067;
		repeat (3) @(negedge clk_sys);
		chk("oc event", 1'b0, ocFaultEvent);
		ioutQuarterAmps = 16'h0068;
		repeat (2) @(negedge clk_sys);
		chk("oc event", 1'b1, ocFaultEvent);
		chk("oc flag", 1'b1, statusByte[SB_IOUT_OC]);
		ioutQuarterAmps = 16'h0000;
		clr();
		$display("test overcurrent done");

		// Immediate shutdown, latched; 810 rounds down to 80 percent
		cmd(1'b1, CMD_UV_RESPONSE, 16'h0080, 8'h00);
		cmd(1'b1, CMD_UV_LIMIT, 16'h032A, 8'h00);
		opOn = 1'b1;
		voutSense = 16'h0320;
		repeat (3) @(negedge clk_sys);
		chk("uv at step", 1'b0, uvFaultFlag);
		voutSense = 16'h031F;
		repeat (2) @(negedge clk_sys);
		chk("uv flag", 1'b1, uvFaultFlag);
		chk("nota bit", 1'b1, statusByte[SB_NOTA]);
		chk("vout bit", 1'b1, statusWord[SW_VOUT]);
		chk("vout status", 16'(1 << SV_UV_FAULT), statusVout);
		chk("output off", 1'b0, outputEnable);
		voutSense = 16'h03E8;
		repeat (100) @(negedge clk_sys);
		chk("latched", 1'b0, outputEnable);
		opOn = 1'b0;
		@(negedge clk_sys);
		opOn = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk("restart", 1'b1, outputEnable);
		clr();

		// Delayed shutdown by seven ticks, endless hiccup of 7 rise times
		cmd(1'b1, CMD_UV_RESPONSE, 16'h007F, 8'h00);
		voutSense = 16'h031F;
		wait_oe(1'b0, 500);
		chk("delay seven", 1'b1, n > 250 && n < 500);
		wait_oe(1'b1, 400);
		chk("hiccup", 16'(7 * 20), 16'(n));
		opOn = 1'b0;
		voutSense = 16'h03E8;
		clr();

		// Ignore: fault flagged while the output stays on
		cmd(1'b1, CMD_UV_RESPONSE, 16'h0000, 8'h00);
		opOn = 1'b1;
		voutSense = 16'h031F;
		repeat (20) @(negedge clk_sys);
		chk("ignore on", 1'b1, outputEnable);
		chk("ignore flag", 1'b1, uvFaultFlag);

		// One retry, a start-up clears the count, then latched off
		startupDone = 1'b1;
		cmd(1'b1, CMD_UV_RESPONSE, 16'h0088, 8'h00);
		wait_oe(1'b0, 10);
		wait_oe(1'b1, 100);
		chk("one hiccup", 16'h0014, 16'(n));
		wait_oe(1'b0, 10);
		startupDone = 1'b0;
		wait_oe(1'b1, 100);
		chk("retry after start", 16'h0014, 16'(n));
		wait_oe(1'b0, 10);
		wait_oe(1'b1, 200);
		chk("latched after retry", 1'b0, outputEnable);
		opOn = 1'b0;
		voutSense = 16'h03E8;
		clr();
		$display("test undervoltage done");
		end_of_test();
	end
endmodule
